// *** src/urxe_pkg.sv ***
// shared constants of the receive status block
package urxe_pkg;
  // apb register byte addresses
  localparam logic [3:0] URXE_OFS_CTRL = 4'h0;
  localparam logic [3:0] URXE_OFS_STAT = 4'h4;
  localparam logic [3:0] URXE_OFS_DATA = 4'h8;
  localparam logic [3:0] URXE_OFS_BAUD = 4'hc;
  // control field positions
  localparam int URXE_CTL_SERIAL_PORT_ENABLE  = 0;
  localparam int URXE_CTL_CONTINUOUS_RECEIVE_ENABLE  = 1;
  localparam int URXE_CTL_RX9   = 2;
  localparam int URXE_CTL_ADDRESS_DETECT_ENABLE = 3;
  // status field positions
  localparam int URXE_ST_FRAMING_ERROR_FLAG  = 0;
  localparam int URXE_ST_OVERRUN_ERROR_FLAG  = 1;
  localparam int URXE_ST_RECEIVED_NINTH_BIT  = 2;
  localparam int URXE_ST_RECEIVE_INTERRUPT_FLAG  = 3;
  localparam int URXE_ST_BUSY  = 4;
  // fifo entry layout: {framing_error_flag, ninth bit, data}
  localparam int URXE_ENT_W    = 10;
  localparam int URXE_ENT_FRAMING_ERROR_FLAG = 9;
  localparam int URXE_ENT_B9   = 8;
  // reset values
  localparam logic [3:0]  URXE_CTRL_RST = 4'h0;
  localparam logic [15:0] URXE_BAUD_RST = 16'h0000;
  // oversampling: sixteen ticks a bit, start checked at mid bit
  localparam logic [3:0] URXE_OS_LAST = 4'hf;
  localparam logic [3:0] URXE_OS_MID  = 4'h7;
  localparam logic [3:0] URXE_BITS8   = 4'h7;
  localparam logic [3:0] URXE_BITS9   = 4'h8;
  // fifo depth
  localparam logic [1:0] URXE_FIFO_FULL = 2'h2;
  typedef enum logic [3:0] {
    URXE_IDLE  = 4'b0001,
    URXE_START = 4'b0010,
    URXE_DATA  = 4'b0100,
    URXE_STOP  = 4'b1000
  } urxe_state_e;
endpackage

// *** src/urxe_fifo_if.sv ***
// connection between receiver and its two-entry fifo
`timescale 1ns/1ps
`default_nettype none
interface urxe_fifo_if;
  import urxe_pkg::*;
  logic                  push;
  logic [URXE_ENT_W-1:0] wdata;
  logic                  pop;
  logic                  flush;
  logic [URXE_ENT_W-1:0] head;
  logic [1:0]            count;
  modport ctl (output push, wdata, pop, flush, input head, count);
  modport mem (input push, wdata, pop, flush, output head, count);
endinterface
`default_nettype wire

// *** src/urxe_fifo.sv ***
// two-entry shifting receive fifo, head comes from a register
`timescale 1ns/1ps
`default_nettype none
module urxe_fifo (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fifo port
  urxe_fifo_if.mem f
);
  import urxe_pkg::*;
  logic [URXE_ENT_W-1:0] e1_q;
  logic [1:0]            cnt_q;
  logic                  do_pop;
  logic                  do_push;

  assign do_pop  = f.pop && cnt_q != 2'h0;
  assign do_push = f.push && (cnt_q != URXE_FIFO_FULL || do_pop);
  assign f.count = cnt_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 2'h0;
      f.head <= '0;
      e1_q   <= '0;
    end else if (f.flush) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'(do_push) - 2'(do_pop);
      // head moves up on a pop; a push lands in the first free slot
      if (do_pop) begin
        f.head <= (cnt_q == URXE_FIFO_FULL) ? e1_q : f.wdata;
        if (do_push && cnt_q == URXE_FIFO_FULL) begin
          e1_q <= f.wdata;
        end
      end else if (do_push) begin
        if (cnt_q == 2'h0) begin
          f.head <= f.wdata;
        end else begin
          e1_q <= f.wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** src/urxe_top.sv ***
// receive framing, overrun, nine-bit and address filter with apb slave
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each fifo entry keeps its own framing status and the flag shows the oldest one.
// - A framing error is recorded when the stop bit sample is low.
// - The framing flag is read-only and a data read advances to the next entry.
// - A character with a framing error does not block further reception.
// - Clearing the port enable resets the port and clears the framing flag.
// - Clearing the continuous receive enable leaves the framing flag alone.
// - A framing error alone raises no interrupt.
// - If every held character has a framing error the flag stays set across reads.
// - The fifo holds two characters and a third one completed while full sets overrun.
// - During overrun held characters stay readable and no new ones are taken.
// - Overrun is cleared only by clearing receive enable or port enable.
// - In nine-bit mode nine data bits are shifted in per character.
// - The ninth bit of the oldest character is shown until its low byte is read.
// - Address detection has an enable bit and works only with nine-bit mode.
// - With address detection only ninth-bit-set characters enter the fifo.
module urxe_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line and flag
  input  wire logic        rx_in,
  output logic             rx_irq
);
  import urxe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  urxe_fifo_if fi ();
  urxe_fifo u_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .f     (fi.mem)
  );

  logic [3:0]   ctrl_q;
  logic [15:0]  baud_q;
  logic         overrun_error_flag_q;
  logic         rx_s1_q;
  logic         rx_s2_q;
  logic [15:0]  bcnt_q;
  logic         os_tick;
  urxe_state_e  st_q;
  logic [3:0]   tcnt_q;
  logic [3:0]   nbit_q;
  logic [8:0]   sh_q;
  logic         done_q;
  logic         bad_q;
  logic         serial_port_enable;
  logic         continuous_receive_enable;
  logic         rx9;
  logic         address_detect_enable;
  logic         acc;
  logic         wr_fire;
  logic         rd_fire;
  logic         pop_pend_q;
  logic         filt_ok;
  logic [URXE_ENT_W-1:0] char_w;
  logic         framing_error_flag_flag;
  logic         received_ninth_bit_flag;

  assign serial_port_enable  = ctrl_q[URXE_CTL_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable  = ctrl_q[URXE_CTL_CONTINUOUS_RECEIVE_ENABLE];
  assign rx9   = ctrl_q[URXE_CTL_RX9];
  assign address_detect_enable = ctrl_q[URXE_CTL_ADDRESS_DETECT_ENABLE] && rx9;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait state so read data leave a flop
  assign acc     = psel && penable;
  assign wr_fire = acc && pready && pwrite;
  assign rd_fire = acc && pready && !pwrite;

  assign framing_error_flag_flag = fi.head[URXE_ENT_FRAMING_ERROR_FLAG] && fi.count != 2'h0;
  assign received_ninth_bit_flag = fi.head[URXE_ENT_B9] && fi.count != 2'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0;
      pop_pend_q <= 1'b0;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= !(hit(paddr, URXE_OFS_CTRL) || hit(paddr, URXE_OFS_STAT) ||
                   hit(paddr, URXE_OFS_DATA) || hit(paddr, URXE_OFS_BAUD));
      prdata  <= 32'h0;
      pop_pend_q <= !pwrite && hit(paddr, URXE_OFS_DATA) &&
                    fi.count != 2'h0;
      if (!pwrite) begin
        if (hit(paddr, URXE_OFS_CTRL)) begin
          prdata <= {28'h0, ctrl_q};
        end else if (hit(paddr, URXE_OFS_STAT)) begin
          prdata <= {27'h0, st_q != URXE_IDLE, fi.count != 2'h0,
                     received_ninth_bit_flag, overrun_error_flag_q, framing_error_flag_flag};
        end else if (hit(paddr, URXE_OFS_DATA)) begin
          prdata <= {24'h0, fi.head[7:0]};
        end else if (hit(paddr, URXE_OFS_BAUD)) begin
          prdata <= {16'h0, baud_q};
        end
      end
    end else begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      pop_pend_q <= 1'b0;
    end
  end

  // data read pops only when a character was there at capture time
  assign fi.pop = rd_fire && pop_pend_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= URXE_CTRL_RST;
      baud_q <= URXE_BAUD_RST;
    end else if (wr_fire && !pslverr) begin
      if (hit(paddr, URXE_OFS_CTRL)) begin
        ctrl_q <= pwdata[3:0];
      end
      if (hit(paddr, URXE_OFS_BAUD)) begin
        baud_q <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line synchroniser and oversample divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign os_tick = serial_port_enable && bcnt_q == 16'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q <= 16'h0;
    end else if (!serial_port_enable || bcnt_q == 16'h0) begin
      bcnt_q <= baud_q;
    end else begin
      bcnt_q <= bcnt_q - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter; runs only while port and receive are enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= URXE_IDLE;
      tcnt_q <= 4'h0;
      nbit_q <= 4'h0;
      sh_q   <= 9'h0;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!serial_port_enable || !continuous_receive_enable) begin
        st_q <= URXE_IDLE;
      end else begin
        unique case (st_q)
          URXE_IDLE: begin
            tcnt_q <= 4'h0;
            if (!rx_s2_q) begin
              st_q <= URXE_START;
            end
          end
          URXE_START: begin
            if (os_tick) begin
              tcnt_q <= tcnt_q + 4'h1;
              if (tcnt_q == URXE_OS_MID) begin
                tcnt_q <= 4'h0;
                nbit_q <= 4'h0;
                // glitch filter: start must still be low at mid bit
                st_q   <= rx_s2_q ? URXE_IDLE : URXE_DATA;
              end
            end
          end
          URXE_DATA: begin
            if (os_tick) begin
              tcnt_q <= tcnt_q + 4'h1;
              if (tcnt_q == URXE_OS_LAST) begin
                sh_q   <= {rx_s2_q, sh_q[8:1]};
                nbit_q <= nbit_q + 4'h1;
                if (nbit_q == (rx9 ? URXE_BITS9 : URXE_BITS8)) begin
                  st_q <= URXE_STOP;
                end
              end
            end
          end
          URXE_STOP: begin
            if (os_tick) begin
              tcnt_q <= tcnt_q + 4'h1;
              if (tcnt_q == URXE_OS_LAST) begin
                done_q <= 1'b1;
                bad_q  <= !rx_s2_q;
                st_q   <= URXE_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delivery into the fifo, address filter and overrun
  assign char_w  = rx9 ? {bad_q, sh_q} : {bad_q, 1'b0, sh_q[8:1]};
  assign filt_ok = !address_detect_enable || char_w[URXE_ENT_B9];
  // framing status is stored, never a reason to refuse
  assign fi.wdata = char_w;
  // a pop in the same cycle frees a slot, so a full fifo still takes it
  assign fi.push  = done_q && serial_port_enable && continuous_receive_enable && !overrun_error_flag_q && filt_ok &&
                    (fi.count != URXE_FIFO_FULL || fi.pop);
  // continuous_receive_enable stops the shifter and clears overrun; the fifo and its flags stay
  assign fi.flush = !serial_port_enable;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_error_flag_q <= 1'b0;
    end else if (!serial_port_enable || !continuous_receive_enable) begin
      overrun_error_flag_q <= 1'b0;
    end else if (done_q && filt_ok && fi.count == URXE_FIFO_FULL &&
                 !fi.pop) begin
      overrun_error_flag_q <= 1'b1;
    end
  end

  // flag lags the fifo count by one cycle; framing plays no part
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= fi.count != 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_irq_tracks_fifo: assert property (@(posedge mclk) disable iff (!rst_n)
    (fi.count != 2'h0) |=> rx_irq)
    else $error("receive flag low while fifo holds data");

  chk_irq_when_empty: assert property (@(posedge mclk) disable iff (!rst_n)
    (fi.count == 2'h0) |=> !rx_irq)
    else $error("receive flag high with empty fifo");

  chk_overrun_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    (done_q && serial_port_enable && continuous_receive_enable && filt_ok && fi.count == URXE_FIFO_FULL &&
     !fi.pop) |=> overrun_error_flag_q)
    else $error("third character while full did not set overrun");

  chk_overrun_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (overrun_error_flag_q && serial_port_enable && continuous_receive_enable) |=> overrun_error_flag_q)
    else $error("overrun cleared while enables stayed set");

  chk_no_push_overrun_error_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    overrun_error_flag_q |-> !fi.push)
    else $error("character accepted during overrun");

  chk_addr_filter: assert property (@(posedge mclk) disable iff (!rst_n)
    (fi.push && ctrl_q[URXE_CTL_ADDRESS_DETECT_ENABLE] && rx9) |-> fi.wdata[URXE_ENT_B9])
    else $error("address mode passed a ninth-bit-clear character");

  chk_serial_port_enable_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    !serial_port_enable |=> (fi.count == 2'h0 && !overrun_error_flag_q && !framing_error_flag_flag))
    else $error("port disable did not reset fifo and flags");

  chk_continuous_receive_enable_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    (serial_port_enable && !continuous_receive_enable && !fi.pop) |=> $stable(framing_error_flag_flag))
    else $error("framing flag changed by receive disable");

  chk_pop_advance: assert property (@(posedge mclk) disable iff (!rst_n)
    (fi.pop && !fi.push && fi.count == URXE_FIFO_FULL && serial_port_enable) |=>
      fi.count == 2'h1)
    else $error("data read did not advance the fifo");

  chk_eight_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    (fi.push && !rx9) |-> !fi.wdata[URXE_ENT_B9])
    else $error("ninth bit set in eight-bit mode");
endmodule
`default_nettype wire

// *** tb/urxe_tx_model.sv ***
// serial transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module urxe_tx_model (
  // clock
  input  wire logic mclk,
  // serial line
  output logic      rx_in
);
  initial rx_in = 1'b1;
  // lsb first, one stop bit; idle high after the frame
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int bc);
    int i;
    rx_in <= 1'b0;
    repeat (bc) @(posedge mclk);
    for (i = 0; i < nb; i++) begin
      rx_in <= d[i];
      repeat (bc) @(posedge mclk);
    end
    // a low stop bit here is what a bad frame looks like
    rx_in <= stp;
    repeat (bc) @(posedge mclk);
    rx_in <= 1'b1;
    repeat (bc) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the receive status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import urxe_pkg::*;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, rx_in;
  logic        rx_irq;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          bad_count, checks_done, seed, bc;
  logic [8:0]  c [4];
  urxe_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_in), .rx_irq(rx_irq));
  urxe_tx_model tx (.mclk(mclk), .rx_in(rx_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // monitor: every completed read takes the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1ffffffff);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // apb master; the caller stands just after a rising edge
  task automatic apb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [32:0] st(logic f, logic o, logic b, logic e);
    st = 33'({e, b, o, f});
  endfunction
  task automatic snd(input int k, input int nb, input logic stp);
    tx.send(c[k], nb, stp, bc);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    bad_count = 0;
    checks_done = 0;
    seed = 64859;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(URXE_OFS_CTRL, 33'h0);
    rd(URXE_OFS_BAUD, 33'h0);
    rd(4'h2, 33'h100000000);
    bc = 16 * (($random(seed) & 1) + 1);
    apb(1'b1, URXE_OFS_BAUD, 32'(bc / 16 - 1));
    rd(URXE_OFS_BAUD, 33'(bc / 16 - 1));
    foreach (c[i]) c[i] = 9'($random(seed));
    apb(1'b1, URXE_OFS_CTRL, 32'h3);
    snd(0, 8, 1'b1);
    snd(1, 8, 1'b0);
    chk(33'(rx_irq), 33'h1);
    rd(URXE_OFS_STAT, st(0, 0, 0, 1));
    rd(URXE_OFS_DATA, 33'(c[0][7:0]));
    rd(URXE_OFS_STAT, st(1, 0, 0, 1));
    rd(URXE_OFS_DATA, 33'(c[1][7:0]));
    rd(URXE_OFS_STAT, st(0, 0, 0, 0));
    for (int k = 0; k < 4; k++) snd(k, 8, 1'b1);
    rd(URXE_OFS_STAT, st(0, 1, 0, 1));
    rd(URXE_OFS_DATA, 33'(c[0][7:0]));
    rd(URXE_OFS_DATA, 33'(c[1][7:0]));
    rd(URXE_OFS_STAT, st(0, 1, 0, 0));
    apb(1'b1, URXE_OFS_CTRL, 32'h1);
    rd(URXE_OFS_STAT, st(0, 0, 0, 0));
    apb(1'b1, URXE_OFS_CTRL, 32'h3);
    snd(2, 8, 1'b0);
    snd(3, 8, 1'b0);
    rd(URXE_OFS_DATA, 33'(c[2][7:0]));
    rd(URXE_OFS_STAT, st(1, 0, 0, 1));
    apb(1'b1, URXE_OFS_CTRL, 32'h1);
    rd(URXE_OFS_STAT, st(1, 0, 0, 1));
    apb(1'b1, URXE_OFS_CTRL, 32'h0);
    rd(URXE_OFS_STAT, st(0, 0, 0, 0));
    // nine-bit, then address filter with and without nine-bit select
    c[0][8] = 1'b1;
    c[1][8] = 1'b0;
    apb(1'b1, URXE_OFS_CTRL, 32'h7);
    snd(0, 9, 1'b1);
    rd(URXE_OFS_STAT, st(0, 0, 1, 1));
    rd(URXE_OFS_DATA, 33'(c[0][7:0]));
    apb(1'b1, URXE_OFS_CTRL, 32'hf);
    snd(1, 9, 1'b1);
    rd(URXE_OFS_STAT, st(0, 0, 0, 0));
    snd(0, 9, 1'b1);
    // match seen: address filter dropped before the next stop bit
    apb(1'b1, URXE_OFS_CTRL, 32'h7);
    snd(1, 9, 1'b1);
    rd(URXE_OFS_STAT, st(0, 0, 1, 1));
    rd(URXE_OFS_DATA, 33'(c[0][7:0]));
    rd(URXE_OFS_STAT, st(0, 0, 0, 1));
    rd(URXE_OFS_DATA, 33'(c[1][7:0]));
    apb(1'b1, URXE_OFS_CTRL, 32'hb);
    snd(2, 8, 1'b1);
    rd(URXE_OFS_DATA, 33'(c[2][7:0]));
    chk(33'(exp_q.size()), 33'h0);
    conclude();
  end
endmodule
`default_nettype wire
